// [src/bpsc_top.sv]
// battery protection state control: short, charge overcurrent, standby, watchdog
`timescale 1ns/100ps
module bpsc_top #(
  parameter int SHORT_DETECT_DELAY_US       = 250,
  parameter int CHARGE_OVERCURRENT_DELAY_US = 8000,
  parameter int CHARGE_RELEASE_DELAY_US     = 2000,
  parameter int DISCHARGE_RELEASE_DELAY_US  = 2000,
  parameter int STANDBY_DETECT_DELAY_US     = 1000,
  parameter int STANDBY_RELEASE_DELAY_US    = 2000,
  parameter int WATCHDOG_TIMEOUT_US         = 1000000,
  parameter int WATCHDOG_RELEASE_DELAY_US   = 100000
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       sense_short_cmp,
  input  wire logic       sense_charge_oc_cmp,
  input  wire logic       standby_request_pin,
  input  wire logic       watchdog_kick_pin,
  input  wire logic       pm_below_discharge_rel,
  input  wire logic       pm_above_charge_rel,
  input  wire logic       pm_above_charger_det,
  input  wire logic       pm_above_short2,
  input  wire logic       charger_voltage_ok,
  input  wire logic       cell_at_inhibit_level,
  input  wire logic       system_power_lost,
  input  wire logic [1:0] discharge_release_type,
  input  wire logic       zero_volt_mode,
  input  wire logic       watchdog_release_mode,
  output logic            charge_gate_out,
  output logic            discharge_gate_out,
  output logic            pm_pullup_en,
  output logic            pm_pulldown_en,
  output logic            pm_pulldown_high_r,
  output logic            short_active,
  output logic            charge_oc_active,
  output logic            standby_detected,
  output logic            standby_active,
  output logic            forced_reset_active
);
  // delay counts in cycles, never below one
  function automatic logic [bpsc_pkg::CNT_W-1:0] us_to_cyc(input int us);
    int c;
    c = us * bpsc_pkg::CLK_FREQ_MHZ;
    if (c < 1)
      c = 1;
    return c[bpsc_pkg::CNT_W-1:0];
  endfunction

  localparam logic [bpsc_pkg::CNT_W-1:0] LIMITS [bpsc_pkg::NUM_TMR] = '{
    us_to_cyc(SHORT_DETECT_DELAY_US),
    us_to_cyc(CHARGE_OVERCURRENT_DELAY_US),
    us_to_cyc(CHARGE_RELEASE_DELAY_US),
    us_to_cyc(DISCHARGE_RELEASE_DELAY_US),
    us_to_cyc(STANDBY_DETECT_DELAY_US),
    us_to_cyc(STANDBY_RELEASE_DELAY_US),
    us_to_cyc(WATCHDOG_TIMEOUT_US),
    us_to_cyc(WATCHDOG_RELEASE_DELAY_US)
  };

  logic [bpsc_pkg::NUM_SYN-1:0] async_in;
  logic [bpsc_pkg::NUM_SYN-1:0] sync1_q;
  logic [bpsc_pkg::NUM_SYN-1:0] sync2_q;
  logic                         kick_prev_q;
  logic                         kick_edge;
  logic                         cfg_taken_q;
  logic [1:0]                   rel_type_q;
  logic                         zv_mode_q;
  logic                         wd_mode_q;
  logic                         short2_seen_q;
  logic [bpsc_pkg::NUM_TMR-1:0] tmr_cond;
  logic [bpsc_pkg::NUM_TMR-1:0] tmr_done;
  logic                         wd_active;
  logic                         charge_allowed;
  logic                         rel_latch;
  bpsc_pkg::bpsc_state_t        state_q;
  bpsc_pkg::bpsc_state_t        state_d;

  // gather asynchronous comparator and pin inputs
  assign async_in[bpsc_pkg::SYN_SHORT]   = sense_short_cmp;
  assign async_in[bpsc_pkg::SYN_CHG_OC]  = sense_charge_oc_cmp;
  assign async_in[bpsc_pkg::SYN_STB]     = standby_request_pin;
  assign async_in[bpsc_pkg::SYN_KICK]    = watchdog_kick_pin;
  assign async_in[bpsc_pkg::SYN_PM_DREL] = pm_below_discharge_rel;
  assign async_in[bpsc_pkg::SYN_PM_CREL] = pm_above_charge_rel;
  assign async_in[bpsc_pkg::SYN_PM_CDET] = pm_above_charger_det;
  assign async_in[bpsc_pkg::SYN_PM_SH2]  = pm_above_short2;
  assign async_in[bpsc_pkg::SYN_CHGR_OK] = charger_voltage_ok;
  assign async_in[bpsc_pkg::SYN_CELL_LO] = cell_at_inhibit_level;
  assign async_in[bpsc_pkg::SYN_SYS_OFF] = system_power_lost;

  // two-stage synchroniser, the first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  // kick edge detector on the synchronised level, either direction
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      kick_prev_q <= 1'b0;
    else
      kick_prev_q <= sync2_q[bpsc_pkg::SYN_KICK];
  end

  assign kick_edge = sync2_q[bpsc_pkg::SYN_KICK] ^ kick_prev_q;

  // option straps caught once after reset release, then frozen
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cfg_taken_q <= 1'b0;
      rel_type_q  <= bpsc_pkg::REL_AUTO1;
      zv_mode_q   <= bpsc_pkg::ZV_PERMIT;
      wd_mode_q   <= bpsc_pkg::WD_REL_AUTO;
    end
    else if (!cfg_taken_q)
    begin
      cfg_taken_q <= 1'b1;
      rel_type_q  <= discharge_release_type;
      zv_mode_q   <= zero_volt_mode;
      wd_mode_q   <= watchdog_release_mode;
    end
  end

  // types other than the two auto types behave as latch
  assign rel_latch = (rel_type_q != bpsc_pkg::REL_AUTO1) &&
                     (rel_type_q != bpsc_pkg::REL_AUTO2);

  // watchdog supervises the host only in the normal, short and charge overcurrent states
  assign wd_active = cfg_taken_q &&
                     ((state_q == bpsc_pkg::ST_NORMAL) ||
                      (state_q == bpsc_pkg::ST_SHORT) ||
                      (state_q == bpsc_pkg::ST_CHG_OC));

  // qualifying conditions; a drop restarts the matching counter
  always_comb
  begin
    tmr_cond = '0;
    tmr_cond[bpsc_pkg::TMR_SHORT_DET] = cfg_taken_q &&
      (state_q == bpsc_pkg::ST_NORMAL) &&
      sync2_q[bpsc_pkg::SYN_SHORT];
    tmr_cond[bpsc_pkg::TMR_CHG_DET] = cfg_taken_q &&
      (state_q == bpsc_pkg::ST_NORMAL) &&
      sync2_q[bpsc_pkg::SYN_CHG_OC];
    tmr_cond[bpsc_pkg::TMR_CHG_REL] =
      (state_q == bpsc_pkg::ST_CHG_OC) &&
      sync2_q[bpsc_pkg::SYN_PM_CREL];
    tmr_cond[bpsc_pkg::TMR_DIS_REL] =
      (state_q == bpsc_pkg::ST_SHORT) &&
      sync2_q[bpsc_pkg::SYN_PM_DREL];
    tmr_cond[bpsc_pkg::TMR_STB_DET] = wd_active &&
      sync2_q[bpsc_pkg::SYN_STB];
    tmr_cond[bpsc_pkg::TMR_STB_REL] =
      (state_q == bpsc_pkg::ST_STB) && short2_seen_q &&
      !sync2_q[bpsc_pkg::SYN_PM_CDET];
    tmr_cond[bpsc_pkg::TMR_WD_TMO] = wd_active && !kick_edge;
    tmr_cond[bpsc_pkg::TMR_WD_REL] =
      (state_q == bpsc_pkg::ST_WD_RESET) &&
      ((wd_mode_q == bpsc_pkg::WD_REL_AUTO) ||
       (sync2_q[bpsc_pkg::SYN_SYS_OFF] &&
        sync2_q[bpsc_pkg::SYN_PM_SH2]));
  end

  // one restartable delay counter per qualified condition
  genvar g;
  generate
    for (g = 0; g < bpsc_pkg::NUM_TMR; g++)
    begin : g_tmr
      bpsc_delay #(
        .LIMIT (LIMITS[g])
      ) u_delay (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .cond    (tmr_cond[g]),
        .done    (tmr_done[g])
      );
    end
  endgenerate

  // pack-minus must exceed the short2 level once while in forced standby
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      short2_seen_q <= 1'b0;
    else if (state_q != bpsc_pkg::ST_STB)
      short2_seen_q <= 1'b0;
    else if (sync2_q[bpsc_pkg::SYN_PM_SH2])
      short2_seen_q <= 1'b1;
  end

  // next protection state; watchdog first, then standby, short, charge
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bpsc_pkg::ST_NORMAL:
      begin
        if (tmr_done[bpsc_pkg::TMR_WD_TMO])
          state_d = bpsc_pkg::ST_WD_RESET;
        else if (tmr_done[bpsc_pkg::TMR_STB_DET])
          state_d = bpsc_pkg::ST_STB_DET;
        else if (tmr_done[bpsc_pkg::TMR_SHORT_DET])
          state_d = bpsc_pkg::ST_SHORT;
        else if (tmr_done[bpsc_pkg::TMR_CHG_DET])
          state_d = bpsc_pkg::ST_CHG_OC;
      end
      bpsc_pkg::ST_SHORT:
      begin
        if (tmr_done[bpsc_pkg::TMR_WD_TMO])
          state_d = bpsc_pkg::ST_WD_RESET;
        else if (tmr_done[bpsc_pkg::TMR_STB_DET])
          state_d = bpsc_pkg::ST_STB_DET;
        else if (tmr_done[bpsc_pkg::TMR_DIS_REL])
          state_d = bpsc_pkg::ST_NORMAL;
      end
      bpsc_pkg::ST_CHG_OC:
      begin
        if (tmr_done[bpsc_pkg::TMR_WD_TMO])
          state_d = bpsc_pkg::ST_WD_RESET;
        else if (tmr_done[bpsc_pkg::TMR_STB_DET])
          state_d = bpsc_pkg::ST_STB_DET;
        else if (tmr_done[bpsc_pkg::TMR_CHG_REL])
          state_d = bpsc_pkg::ST_NORMAL;
      end
      bpsc_pkg::ST_STB_DET:
      begin
        if (sync2_q[bpsc_pkg::SYN_PM_CDET])
          state_d = bpsc_pkg::ST_STB;
      end
      bpsc_pkg::ST_STB:
      begin
        if (tmr_done[bpsc_pkg::TMR_STB_REL])
          state_d = bpsc_pkg::ST_NORMAL;
      end
      bpsc_pkg::ST_WD_RESET:
      begin
        if (tmr_done[bpsc_pkg::TMR_WD_REL])
          state_d = bpsc_pkg::ST_NORMAL;
      end
      default:
        state_d = bpsc_pkg::ST_NORMAL;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      state_q <= bpsc_pkg::ST_NORMAL;
    else
      state_q <= state_d;
  end

  // zero-volt charging gate term
  always_comb
  begin
    if (zv_mode_q == bpsc_pkg::ZV_INHIBIT)
      charge_allowed = !sync2_q[bpsc_pkg::SYN_CELL_LO];
    else
      charge_allowed = !sync2_q[bpsc_pkg::SYN_CELL_LO] ||
                       sync2_q[bpsc_pkg::SYN_CHGR_OK];
  end

  // registered gate drivers and pack-minus pull controls
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      charge_gate_out    <= 1'b0;
      discharge_gate_out <= 1'b0;
      pm_pullup_en       <= 1'b0;
      pm_pulldown_en     <= 1'b0;
      pm_pulldown_high_r <= 1'b0;
    end
    else
    begin
      charge_gate_out    <= charge_allowed &&
                            ((state_q == bpsc_pkg::ST_NORMAL) ||
                             (state_q == bpsc_pkg::ST_SHORT));
      discharge_gate_out <= (state_q == bpsc_pkg::ST_NORMAL) ||
                            (state_q == bpsc_pkg::ST_CHG_OC);
      pm_pullup_en       <= (state_q == bpsc_pkg::ST_CHG_OC) ||
                            (state_q == bpsc_pkg::ST_STB_DET) ||
                            (state_q == bpsc_pkg::ST_STB) ||
                            ((state_q == bpsc_pkg::ST_SHORT) &&
                             rel_latch);
      pm_pulldown_en     <= (state_q == bpsc_pkg::ST_SHORT) &&
                            !rel_latch;
      pm_pulldown_high_r <= (state_q == bpsc_pkg::ST_SHORT) &&
                            (rel_type_q == bpsc_pkg::REL_AUTO2);
    end
  end

  // state indications straight from the state register
  assign short_active        = (state_q == bpsc_pkg::ST_SHORT);
  assign charge_oc_active    = (state_q == bpsc_pkg::ST_CHG_OC);
  assign standby_detected    = (state_q == bpsc_pkg::ST_STB_DET);
  assign standby_active      = (state_q == bpsc_pkg::ST_STB);
  assign forced_reset_active = (state_q == bpsc_pkg::ST_WD_RESET);

  // checks on the protection sequence
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_short_entry;
    (state_q == bpsc_pkg::ST_NORMAL) && (state_d == bpsc_pkg::ST_SHORT)
      |-> tmr_cond[bpsc_pkg::TMR_SHORT_DET] &&
          $past(tmr_cond[bpsc_pkg::TMR_SHORT_DET]);
  endproperty
  a_short_entry: assert property (p_short_entry)
    else $error("short state entered without a held short condition");

  property p_short_gate;
    (state_q == bpsc_pkg::ST_SHORT) |=> !discharge_gate_out;
  endproperty
  a_short_gate: assert property (p_short_gate)
    else $error("discharge gate on during short state");

  property p_short_release;
    (state_q == bpsc_pkg::ST_SHORT) ##1 (state_q == bpsc_pkg::ST_NORMAL)
      |-> $past(tmr_done[bpsc_pkg::TMR_DIS_REL]);
  endproperty
  a_short_release: assert property (p_short_release)
    else $error("short released without the release delay");

  property p_short_pull;
    (state_q == bpsc_pkg::ST_SHORT) |=> (pm_pullup_en != pm_pulldown_en) &&
                                        (pm_pullup_en == rel_latch);
  endproperty
  a_short_pull: assert property (p_short_pull)
    else $error("wrong pack-minus pull in short state");

  property p_chg_oc_gate;
    (state_q == bpsc_pkg::ST_CHG_OC) |=> !charge_gate_out && pm_pullup_en;
  endproperty
  a_chg_oc_gate: assert property (p_chg_oc_gate)
    else $error("charge gate on or no pull-up in charge overcurrent");

  property p_chg_release;
    (state_q == bpsc_pkg::ST_CHG_OC) && (state_d == bpsc_pkg::ST_NORMAL)
      |-> sync2_q[bpsc_pkg::SYN_PM_CREL] && $past(sync2_q[bpsc_pkg::SYN_PM_CREL]);
  endproperty
  a_chg_release: assert property (p_chg_release)
    else $error("charge overcurrent released with pack-minus low");

  property p_zv_inhibit;
    (zv_mode_q == bpsc_pkg::ZV_INHIBIT) && sync2_q[bpsc_pkg::SYN_CELL_LO]
      |=> !charge_gate_out;
  endproperty
  a_zv_inhibit: assert property (p_zv_inhibit)
    else $error("charging allowed on an inhibited zero-volt cell");

  property p_stb_off;
    (state_q == bpsc_pkg::ST_STB_DET) |=>
      !charge_gate_out && !discharge_gate_out && pm_pullup_en;
  endproperty
  a_stb_off: assert property (p_stb_off)
    else $error("gates on or no pull-up in standby detected");

  property p_stb_release;
    (state_q == bpsc_pkg::ST_STB) && (state_d == bpsc_pkg::ST_NORMAL)
      |-> short2_seen_q && !sync2_q[bpsc_pkg::SYN_PM_CDET];
  endproperty
  a_stb_release: assert property (p_stb_release)
    else $error("forced standby released without short2 seen");

  property p_wd_kick;
    wd_active && kick_edge |=> (state_q != bpsc_pkg::ST_WD_RESET);
  endproperty
  a_wd_kick: assert property (p_wd_kick)
    else $error("forced reset right after a watchdog kick");

  property p_wd_off;
    (state_q == bpsc_pkg::ST_WD_RESET) |=>
      !charge_gate_out && !discharge_gate_out;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("gates on during forced reset");

  property p_cfg_frozen;
    cfg_taken_q |=> $stable(rel_type_q) && $stable(zv_mode_q) &&
                    $stable(wd_mode_q);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("option setting changed during operation");
endmodule

// [inc/bpsc_pkg.sv]
// constants and types for the battery protection state control
package bpsc_pkg;
  // clock rate, used to turn delay times into cycle counts
  localparam int CLK_FREQ_MHZ = 25;
  // width of every delay counter
  localparam int CNT_W = 28;

  // delay counter slots
  localparam int TMR_SHORT_DET = 0;
  localparam int TMR_CHG_DET   = 1;
  localparam int TMR_CHG_REL   = 2;
  localparam int TMR_DIS_REL   = 3;
  localparam int TMR_STB_DET   = 4;
  localparam int TMR_STB_REL   = 5;
  localparam int TMR_WD_TMO    = 6;
  localparam int TMR_WD_REL    = 7;
  localparam int NUM_TMR       = 8;

  // synchronised comparator and pin inputs
  localparam int SYN_SHORT   = 0;
  localparam int SYN_CHG_OC  = 1;
  localparam int SYN_STB     = 2;
  localparam int SYN_KICK    = 3;
  localparam int SYN_PM_DREL = 4;
  localparam int SYN_PM_CREL = 5;
  localparam int SYN_PM_CDET = 6;
  localparam int SYN_PM_SH2  = 7;
  localparam int SYN_CHGR_OK = 8;
  localparam int SYN_CELL_LO = 9;
  localparam int SYN_SYS_OFF = 10;
  localparam int NUM_SYN     = 11;

  // discharge / short release types
  localparam logic [1:0] REL_AUTO1 = 2'h0;
  localparam logic [1:0] REL_AUTO2 = 2'h1;
  localparam logic [1:0] REL_LATCH = 2'h2;

  // zero-volt charging option
  localparam logic ZV_PERMIT  = 1'h0;
  localparam logic ZV_INHIBIT = 1'h1;

  // watchdog release option
  localparam logic WD_REL_AUTO    = 1'h0;
  localparam logic WD_REL_PM_RISE = 1'h1;

  // protection states, one-hot
  typedef enum logic [5:0] {
    ST_NORMAL   = 6'h01,
    ST_SHORT    = 6'h02,
    ST_CHG_OC   = 6'h04,
    ST_STB_DET  = 6'h08,
    ST_STB      = 6'h10,
    ST_WD_RESET = 6'h20
  } bpsc_state_t;
endpackage

// [src/bpsc_delay.sv]
// qualification delay counter that restarts when its condition drops
`timescale 1ns/100ps
module bpsc_delay #(
  parameter logic [bpsc_pkg::CNT_W-1:0] LIMIT = 28'h0000001
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic cond,
  output logic      done
);
  logic [bpsc_pkg::CNT_W-1:0] cnt_q;
  logic [bpsc_pkg::CNT_W-1:0] cnt_d;

  // count held cycles, saturate at the limit, clear when cond drops
  always_comb
  begin
    cnt_d = cnt_q;
    if (!cond)
      cnt_d = '0;
    else if (cnt_q != LIMIT)
      cnt_d = cnt_q + 1'b1;
  end

  // counter register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  // expired once the condition has held for the full limit
  assign done = cond && (cnt_q == LIMIT);
endmodule

// [tb/bpsc_pack_model.sv]
// far-side model: pack-minus node with charger and load, and the host kick
`timescale 1ns/100ps
module bpsc_pack_model #(
  parameter int KICK_CYC = 40
) (
  input  wire logic ref_clk,
  input  wire logic charger_on,
  input  wire logic load_high,
  input  wire logic kick_en,
  input  wire logic pm_pullup_en,
  output logic      pm_below_discharge_rel,
  output logic      pm_above_charge_rel,
  output logic      watchdog_kick_pin
);
  int   cnt    = 0;
  logic kick_q = 1'b0;
  // pull-up lifts pack-minus unless a charger drags it down
  assign pm_above_charge_rel    = (pm_pullup_en & ~charger_on) | load_high;
  assign pm_below_discharge_rel = ~pm_above_charge_rel;
  // host toggles the kick pin well inside the timeout
  assign watchdog_kick_pin = kick_q;
  always @(posedge ref_clk)
  begin
    cnt <= (cnt >= KICK_CYC - 1) ? 0 : cnt + 1;
    if (kick_en && cnt == KICK_CYC - 1)
      kick_q <= ~kick_q;
  end
endmodule

// [tb/bpsc_top_test.sv]
// self-checking bench for the battery protection state control
`timescale 1ns/100ps
module bpsc_top_test;
  // drive vectors: {charge, discharge, pull-up, pull-down, high-r}
  localparam logic [4:0] SHORT_DRV [4] = '{5'h12, 5'h13, 5'h14, 5'h14};
  // zero-volt table: {mode, cell low, charger ok, expected charge gate}
  localparam logic [3:0] ZV_TAB [4] = '{4'he, 4'h9, 4'h4, 4'h7};
  logic       ref_clk                = 1'b0;
  logic       reset_n                = 1'b0;
  logic       sense_short_cmp;
  logic       sense_charge_oc_cmp;
  logic       standby_request_pin;
  logic       charger_voltage_ok;
  logic       cell_at_inhibit_level;
  logic       system_power_lost;
  logic [1:0] discharge_release_type;
  logic       zero_volt_mode;
  logic       watchdog_release_mode;
  logic       charger_on;
  logic       load_high;
  logic       kick_en;
  logic       watchdog_kick_pin;
  logic       pm_below_discharge_rel;
  logic       pm_above_charge_rel;
  logic       pm_above_charger_det;
  logic       pm_above_short2;
  logic       charge_gate_out;
  logic       discharge_gate_out;
  logic       pm_pullup_en;
  logic       pm_pulldown_en;
  logic       pm_pulldown_high_r;
  logic       short_active;
  logic       charge_oc_active;
  logic       standby_detected;
  logic       standby_active;
  logic       forced_reset_active;
  int         failures               = 0;
  int         checks                 = 0;
  wire  [4:0] st = {forced_reset_active, standby_active, standby_detected,
                    charge_oc_active, short_active};
  wire  [4:0] drv = {charge_gate_out, discharge_gate_out, pm_pullup_en,
                     pm_pulldown_en, pm_pulldown_high_r};
  // one pack-minus level feeds every pack-minus comparator
  assign pm_above_charger_det = pm_above_charge_rel;
  assign pm_above_short2      = pm_above_charge_rel;
  // delays of 1 or 2 us give counts of 25 or 50 cycles
  bpsc_top #(
    .SHORT_DETECT_DELAY_US       (1),
    .CHARGE_OVERCURRENT_DELAY_US (1),
    .CHARGE_RELEASE_DELAY_US     (2),
    .DISCHARGE_RELEASE_DELAY_US  (2),
    .STANDBY_DETECT_DELAY_US     (1),
    .STANDBY_RELEASE_DELAY_US    (2),
    .WATCHDOG_TIMEOUT_US         (8),
    .WATCHDOG_RELEASE_DELAY_US   (2)
  ) bpsc_top_i (
    .ref_clk                (ref_clk),
    .reset_n                (reset_n),
    .sense_short_cmp        (sense_short_cmp),
    .sense_charge_oc_cmp    (sense_charge_oc_cmp),
    .standby_request_pin    (standby_request_pin),
    .watchdog_kick_pin      (watchdog_kick_pin),
    .pm_below_discharge_rel (pm_below_discharge_rel),
    .pm_above_charge_rel    (pm_above_charge_rel),
    .pm_above_charger_det   (pm_above_charger_det),
    .pm_above_short2        (pm_above_short2),
    .charger_voltage_ok     (charger_voltage_ok),
    .cell_at_inhibit_level  (cell_at_inhibit_level),
    .system_power_lost      (system_power_lost),
    .discharge_release_type (discharge_release_type),
    .zero_volt_mode         (zero_volt_mode),
    .watchdog_release_mode  (watchdog_release_mode),
    .charge_gate_out        (charge_gate_out),
    .discharge_gate_out     (discharge_gate_out),
    .pm_pullup_en           (pm_pullup_en),
    .pm_pulldown_en         (pm_pulldown_en),
    .pm_pulldown_high_r     (pm_pulldown_high_r),
    .short_active           (short_active),
    .charge_oc_active       (charge_oc_active),
    .standby_detected       (standby_detected),
    .standby_active         (standby_active),
    .forced_reset_active    (forced_reset_active)
  );
  bpsc_pack_model bpsc_pack_model_i (
    .ref_clk                (ref_clk),
    .charger_on             (charger_on),
    .load_high              (load_high),
    .kick_en                (kick_en),
    .pm_pullup_en           (pm_pullup_en),
    .pm_below_discharge_rel (pm_below_discharge_rel),
    .pm_above_charge_rel    (pm_above_charge_rel),
    .watchdog_kick_pin      (watchdog_kick_pin)
  );
  always #20 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask
  // bounded wait for one status bit, then compare it
  task automatic wait_st(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (st[idx] !== v && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(5'(st[idx]), 5'(v));
  endtask
  // reset with the static options applied
  task automatic rst(input logic [1:0] t, input logic z, input logic w);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    discharge_release_type <= t;
    zero_volt_mode <= z;
    watchdog_release_mode <= w;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(4);
  endtask
  task automatic test_done;
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #800000;
    failures++;
    test_done;
  end
  initial
  begin
    // idle levels before the first edge
    sense_short_cmp        <= 1'b0;
    sense_charge_oc_cmp    <= 1'b0;
    standby_request_pin    <= 1'b0;
    charger_voltage_ok     <= 1'b0;
    cell_at_inhibit_level  <= 1'b0;
    system_power_lost      <= 1'b0;
    discharge_release_type <= 2'h0;
    zero_volt_mode         <= 1'h0;
    watchdog_release_mode  <= 1'h0;
    charger_on             <= 1'b0;
    load_high              <= 1'b0;
    kick_en                <= 1'b1;
    // short circuit under each release type, code 3 acting as latch
    for (int t = 0; t < 4; t++)
    begin
      rst(2'(t), bpsc_pkg::ZV_PERMIT, bpsc_pkg::WD_REL_AUTO);
      chk(drv, 5'h18);
      @(posedge ref_clk);
      sense_short_cmp <= 1'b1;
      cyc(20);
      @(posedge ref_clk);
      sense_short_cmp <= 1'b0;
      cyc(40);
      chk(st, 5'h00);
      @(posedge ref_clk);
      sense_short_cmp <= 1'b1;
      cyc(24);
      chk(st, 5'h00);
      wait_st(0, 1'b1, 10);
      @(posedge ref_clk);
      sense_short_cmp <= 1'b0;
      cyc(2);
      chk(drv, SHORT_DRV[t]);
      cyc(30);
      chk(st, 5'h01);
      @(posedge ref_clk);
      charger_on <= (t >= 2);
      wait_st(0, 1'b0, 60);
      @(posedge ref_clk);
      charger_on <= 1'b0;
      cyc(2);
      chk(drv, 5'h18);
    end
    // charge overcurrent, released only when the charger leaves
    rst(bpsc_pkg::REL_AUTO1, bpsc_pkg::ZV_PERMIT, bpsc_pkg::WD_REL_AUTO);
    @(posedge ref_clk);
    charger_on <= 1'b1;
    sense_charge_oc_cmp <= 1'b1;
    wait_st(1, 1'b1, 40);
    @(posedge ref_clk);
    sense_charge_oc_cmp <= 1'b0;
    cyc(2);
    chk(drv, 5'h0c);
    cyc(80);
    chk(st, 5'h02);
    @(posedge ref_clk);
    charger_on <= 1'b0;
    cyc(40);
    chk(st, 5'h02);
    wait_st(1, 1'b0, 20);
    // forced standby, requested with no charger present
    @(posedge ref_clk);
    standby_request_pin <= 1'b1;
    wait_st(2, 1'b1, 40);
    wait_st(3, 1'b1, 10);
    cyc(2);
    chk(5'(drv[4:3]), 5'h00);
    @(posedge ref_clk);
    standby_request_pin <= 1'b0;
    cyc(60);
    chk(st, 5'h08);
    @(posedge ref_clk);
    charger_on <= 1'b1;
    cyc(40);
    chk(st, 5'h08);
    wait_st(3, 1'b0, 20);
    @(posedge ref_clk);
    charger_on <= 1'b0;
    cyc(3);
    chk(drv, 5'h18);
    // zero-volt charging options
    for (int i = 0; i < 4; i++)
    begin
      rst(bpsc_pkg::REL_AUTO1, ZV_TAB[i][3], bpsc_pkg::WD_REL_AUTO);
      @(posedge ref_clk);
      cell_at_inhibit_level <= ZV_TAB[i][2];
      charger_voltage_ok <= ZV_TAB[i][1];
      zero_volt_mode <= ~ZV_TAB[i][3];
      cyc(5);
      chk(5'(charge_gate_out), 5'(ZV_TAB[i][0]));
    end
    @(posedge ref_clk);
    cell_at_inhibit_level <= 1'b0;
    charger_voltage_ok <= 1'b0;
    // watchdog with automatic release
    rst(bpsc_pkg::REL_AUTO1, bpsc_pkg::ZV_PERMIT, bpsc_pkg::WD_REL_AUTO);
    cyc(400);
    chk(st, 5'h00);
    @(posedge ref_clk);
    kick_en <= 1'b0;
    cyc(150);
    chk(st, 5'h00);
    wait_st(4, 1'b1, 110);
    cyc(2);
    chk(5'(drv[4:3]), 5'h00);
    wait_st(4, 1'b0, 60);
    // watchdog released by power loss and rising pack-minus
    rst(bpsc_pkg::REL_AUTO1, bpsc_pkg::ZV_PERMIT, bpsc_pkg::WD_REL_PM_RISE);
    wait_st(4, 1'b1, 260);
    @(posedge ref_clk);
    load_high <= 1'b1;
    cyc(100);
    chk(st, 5'h10);
    @(posedge ref_clk);
    system_power_lost <= 1'b1;
    wait_st(4, 1'b0, 70);
    test_done;
  end
endmodule
